//--- hdl/pccb_consts.vh
`ifndef PCCB_CONSTS_VH
`define PCCB_CONSTS_VH

// register indices; byte address is four times the index
`define PCCB_IDX_T1_COUNT 5'h00
`define PCCB_IDX_PC_DIR 5'h07
`define PCCB_IDX_PA_PULL 5'h09
`define PCCB_IDX_PS0_COUNT 5'h0a
`define PCCB_IDX_PC_PULLDN 5'h0b
`define PCCB_IDX_PB_OD 5'h0c
`define PCCB_IDX_PC_OD 5'h0d
`define PCCB_IDX_CMP_SEL 5'h0e
`define PCCB_IDX_PWR_CTL1 5'h0f
`define PCCB_IDX_T1_HIGH 5'h10

// reset values
`define PCCB_RST_PC_DIR 2'h3
`define PCCB_RST_PA_PULL 8'hff
`define PCCB_RST_PC_PULLDN 2'h3
`define PCCB_RST_PB_OD 8'h00
`define PCCB_RST_PC_OD 2'h0
`define PCCB_RST_CMP_SEL 8'h0c
`define PCCB_RST_PWR_CTL1 7'h1d
`define PCCB_RST_T1_HIGH 2'h0

// field positions
`define PCCB_PA_PULLDN_BIT 5
`define PCCB_CMP_REF_LSB 0
`define PCCB_CMP_PAD_LSB 4
`define PCCB_PWR_GIE_BIT 7
`define PCCB_PWR_LVD_BIT 6
`define PCCB_PWR_SP5_BIT 5
`define PCCB_PWR_LVS_LSB 2
`define PCCB_PWR_SP1_BIT 1
`define PCCB_PWR_T0EN_BIT 0
`define PCCB_T1H_LSB 4
`define PCCB_CMP_NO_PAD 4'h5

`endif

//--- hdl/pccb_cmp_mux.v
`include "pccb_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// pad codes: bit 3 selects port B, bits 2:0 the pin number
module pccb_cmp_mux (
    input wire [3:0] ref_sel_i,
    input wire [3:0] pad_sel_i,
    output reg pair_mode_o,
    output reg [3:0] ref_level_o,
    output reg [3:0] pos_pad_o,
    output reg pos_valid_o,
    output reg [3:0] neg_pad_o,
    output reg neg_is_pad_o
);
    always @* begin
        pair_mode_o = (ref_sel_i == 4'h0);
        ref_level_o = ref_sel_i;
        pos_pad_o = pad_sel_i;
        pos_valid_o = (pad_sel_i != `PCCB_CMP_NO_PAD);
        neg_pad_o = 4'h0;
        neg_is_pad_o = 1'b0;
        if (pair_mode_o) begin
            pos_valid_o = 1'b1;
            neg_is_pad_o = 1'b1;
            // first half of the codes lead with port A 0-3
            if (pad_sel_i[3] == 1'b0) begin
                pos_pad_o = {2'b00, pad_sel_i[1:0]};
            end else begin
                pos_pad_o = {1'b1, 3'h2 + {1'b0, pad_sel_i[1:0]}};
            end
            case (pad_sel_i)
                4'h0: neg_pad_o = 4'h1;
                4'h1: neg_pad_o = 4'h0;
                4'h2: neg_pad_o = 4'h3;
                4'h3: neg_pad_o = 4'h2;
                4'h4: neg_pad_o = 4'hb;
                4'h5: neg_pad_o = 4'ha;
                4'h6: neg_pad_o = 4'hd;
                4'h7: neg_pad_o = 4'hc;
                4'h8: neg_pad_o = 4'h1;
                4'h9: neg_pad_o = 4'h0;
                4'ha: neg_pad_o = 4'h3;
                4'hb: neg_pad_o = 4'h2;
                4'hc: neg_pad_o = 4'hb;
                4'hd: neg_pad_o = 4'ha;
                4'he: neg_pad_o = 4'hd;
                4'hf: neg_pad_o = 4'hc;
                default: neg_pad_o = 4'h0;
            endcase
        end
    end
endmodule // pccb_cmp_mux
`default_nettype wire

//--- hdl/pccb_bank.v
`include "pccb_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pccb_bank #(
    parameter ADDR_W = 12,
    parameter IRQ_N = 8
) (
    input wire CORE_CLK_I,
    input wire RSTN_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [ADDR_W-1:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // status sources
    input wire [7:0] PRESCALER0_COUNT_I,
    input wire LOW_VOLTAGE_FLAG_I,
    input wire TIMER1_DEC_I,
    // interrupt gating
    input wire IRQ_ON_INSTRUCTION_I,
    input wire IRQ_OFF_INSTRUCTION_I,
    input wire [IRQ_N-1:0] IRQ_ENABLED_REQ_I,
    output wire IRQ_TAKE_O,
    output wire GLOBAL_IRQ_ENABLE_O,
    // pad control
    output wire [1:0] PORT_C_DIR_O,
    output wire [7:0] PORT_A_PULLHIGH_EN_O,
    output wire PORT_A5_PULLLOW_EN_O,
    output wire [1:0] PORT_C_PULLLOW_EN_O,
    output wire [7:0] PORT_B_OPENDRAIN_O,
    output wire [1:0] PORT_C_OPENDRAIN_O,
    // comparator routing
    output reg CMP_PAIR_MODE_O,
    output reg [3:0] CMP_REF_LEVEL_O,
    output reg [3:0] CMP_POS_PAD_O,
    output reg CMP_POS_VALID_O,
    output reg [3:0] CMP_NEG_PAD_O,
    output reg CMP_NEG_IS_PAD_O,
    // power control and timer1 count
    output wire [2:0] LVD_THRESHOLD_SEL_O,
    output wire TIMER0_EN_O,
    output wire [9:0] TIMER1_COUNT_O
);

    ////////////////////////////////////////////////////////////////////
    // bus decode

    wire [ADDR_W-3:0] word_idx;
    wire idx_hit;
    wire acc;
    wire wr_en;
    wire [7:0] wd;
    reg known;

    assign word_idx = PADDR_I[ADDR_W-1:2];
    // only the low five index bits are decoded when the rest are zero
    assign idx_hit = (word_idx[ADDR_W-3:5] == {(ADDR_W-7){1'b0}});
    assign acc = PSEL_I & PENABLE_I;
    assign wr_en = acc & PWRITE_I & known;
    assign wd = PWDATA_I[7:0];

    always @* begin
        known = 1'b0;
        if (idx_hit && PADDR_I[1:0] == 2'b00) begin
            case (word_idx[4:0])
                `PCCB_IDX_T1_COUNT: known = 1'b1;
                `PCCB_IDX_PC_DIR: known = 1'b1;
                `PCCB_IDX_PA_PULL: known = 1'b1;
                `PCCB_IDX_PS0_COUNT: known = 1'b1;
                `PCCB_IDX_PC_PULLDN: known = 1'b1;
                `PCCB_IDX_PB_OD: known = 1'b1;
                `PCCB_IDX_PC_OD: known = 1'b1;
                `PCCB_IDX_CMP_SEL: known = 1'b1;
                `PCCB_IDX_PWR_CTL1: known = 1'b1;
                `PCCB_IDX_T1_HIGH: known = 1'b1;
                default: known = 1'b0;
            endcase
        end
    end

    // zero wait states; an unmapped access completes with an error
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc & ~known;

    function sel;
        input [4:0] idx;
        begin
            sel = wr_en && (word_idx[4:0] == idx);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // port control registers

    reg [1:0] pc_dir_q;
    reg [7:0] pa_pull_q;
    reg [1:0] pc_pulldn_q;
    reg [7:0] pb_od_q;
    reg [1:0] pc_od_q;
    reg [7:0] cmp_sel_q;

    always @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            pc_dir_q <= `PCCB_RST_PC_DIR;
            pa_pull_q <= `PCCB_RST_PA_PULL;
            pc_pulldn_q <= `PCCB_RST_PC_PULLDN;
            pb_od_q <= `PCCB_RST_PB_OD;
            pc_od_q <= `PCCB_RST_PC_OD;
            cmp_sel_q <= `PCCB_RST_CMP_SEL;
        end else begin
            // unused upper bits are never stored
            if (sel(`PCCB_IDX_PC_DIR)) begin
                pc_dir_q <= wd[1:0];
            end
            if (sel(`PCCB_IDX_PA_PULL)) begin
                pa_pull_q <= wd;
            end
            if (sel(`PCCB_IDX_PC_PULLDN)) begin
                pc_pulldn_q <= wd[1:0];
            end
            if (sel(`PCCB_IDX_PB_OD)) begin
                pb_od_q <= wd;
            end
            if (sel(`PCCB_IDX_PC_OD)) begin
                pc_od_q <= wd[1:0];
            end
            if (sel(`PCCB_IDX_CMP_SEL)) begin
                cmp_sel_q <= wd;
            end
        end
    end

    assign PORT_C_DIR_O = pc_dir_q;

    // pin 5 carries a pull-low instead of a pull-high
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pa_pull
            if (g == `PCCB_PA_PULLDN_BIT) begin : g_none
                assign PORT_A_PULLHIGH_EN_O[g] = 1'b0;
            end else begin : g_ph
                assign PORT_A_PULLHIGH_EN_O[g] = ~pa_pull_q[g];
            end
        end
    endgenerate

    // no interlock with the crystal pads; software must keep 6,7 off
    assign PORT_A5_PULLLOW_EN_O = ~pa_pull_q[`PCCB_PA_PULLDN_BIT];
    assign PORT_C_PULLLOW_EN_O = ~pc_pulldn_q;
    assign PORT_B_OPENDRAIN_O = pb_od_q;
    assign PORT_C_OPENDRAIN_O = pc_od_q;

    ////////////////////////////////////////////////////////////////////
    // comparator routing, registered so the pads see clean codes

    wire cm_pair;
    wire [3:0] cm_ref;
    wire [3:0] cm_pos;
    wire cm_pos_ok;
    wire [3:0] cm_neg;
    wire cm_neg_pad;

    pccb_cmp_mux u_cmp_mux (
        .ref_sel_i(cmp_sel_q[`PCCB_CMP_REF_LSB+3:`PCCB_CMP_REF_LSB]),
        .pad_sel_i(cmp_sel_q[`PCCB_CMP_PAD_LSB+3:`PCCB_CMP_PAD_LSB]),
        .pair_mode_o(cm_pair),
        .ref_level_o(cm_ref),
        .pos_pad_o(cm_pos),
        .pos_valid_o(cm_pos_ok),
        .neg_pad_o(cm_neg),
        .neg_is_pad_o(cm_neg_pad)
    );

    always @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            CMP_PAIR_MODE_O <= 1'b0;
            CMP_REF_LEVEL_O <= 4'h0;
            CMP_POS_PAD_O <= 4'h0;
            CMP_POS_VALID_O <= 1'b0;
            CMP_NEG_PAD_O <= 4'h0;
            CMP_NEG_IS_PAD_O <= 1'b0;
        end else begin
            CMP_PAIR_MODE_O <= cm_pair;
            CMP_REF_LEVEL_O <= cm_ref;
            CMP_POS_PAD_O <= cm_pos;
            CMP_POS_VALID_O <= cm_pos_ok;
            CMP_NEG_PAD_O <= cm_neg;
            CMP_NEG_IS_PAD_O <= cm_neg_pad;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power control: bit 7 enable, 6 detector, 5/1 spare, 4:2 level

    reg gie_q;
    reg [5:0] pwr_q;
    wire [7:0] pwr_rd;
    wire [7:0] pwr_rst;

    assign pwr_rst = {1'b0, `PCCB_RST_PWR_CTL1};

    always @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            gie_q <= pwr_rst[`PCCB_PWR_GIE_BIT];
            pwr_q <= pwr_rst[5:0];
        end else begin
            // the instructions win over a bus write in the same cycle
            if (IRQ_ON_INSTRUCTION_I) begin
                gie_q <= 1'b1;
            end else if (IRQ_OFF_INSTRUCTION_I) begin
                gie_q <= 1'b0;
            end else if (sel(`PCCB_IDX_PWR_CTL1)) begin
                gie_q <= wd[`PCCB_PWR_GIE_BIT];
            end
            if (sel(`PCCB_IDX_PWR_CTL1)) begin
                pwr_q <= wd[5:0];
            end
        end
    end

    // the detector bit is never stored, so writes cannot touch it
    assign pwr_rd = {gie_q, LOW_VOLTAGE_FLAG_I, pwr_q};
    assign GLOBAL_IRQ_ENABLE_O = gie_q;
    assign IRQ_TAKE_O = gie_q & (|IRQ_ENABLED_REQ_I);
    assign LVD_THRESHOLD_SEL_O =
        pwr_q[`PCCB_PWR_LVS_LSB+2:`PCCB_PWR_LVS_LSB];
    assign TIMER0_EN_O = pwr_q[`PCCB_PWR_T0EN_BIT];

    ////////////////////////////////////////////////////////////////////
    // timer1 count and high bits

    reg [1:0] t1_high_q;
    reg [9:0] t1_cnt_q;
    reg [7:0] t1_reload_q;

    always @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            t1_high_q <= `PCCB_RST_T1_HIGH;
            t1_cnt_q <= 10'h000;
            t1_reload_q <= 8'h00;
        end else begin
            if (sel(`PCCB_IDX_T1_HIGH)) begin
                t1_high_q <= wd[`PCCB_T1H_LSB+1:`PCCB_T1H_LSB];
            end
            if (sel(`PCCB_IDX_T1_COUNT)) begin
                t1_reload_q <= wd;
                t1_cnt_q <= {t1_high_q, wd};
            end else if (TIMER1_DEC_I) begin
                // plain wrap; reload policy belongs to the timer control
                t1_cnt_q <= t1_cnt_q - 10'h001;
            end
        end
    end

    assign TIMER1_COUNT_O = t1_cnt_q;

    ////////////////////////////////////////////////////////////////////
    // read mux; data is valid in the access cycle

    reg [7:0] rd;

    always @* begin
        rd = 8'h00;
        if (idx_hit && PADDR_I[1:0] == 2'b00) begin
            case (word_idx[4:0])
                `PCCB_IDX_T1_COUNT: rd = t1_cnt_q[7:0];
                `PCCB_IDX_PC_DIR: rd = {6'h00, pc_dir_q};
                `PCCB_IDX_PA_PULL: rd = pa_pull_q;
                `PCCB_IDX_PS0_COUNT: rd = PRESCALER0_COUNT_I;
                `PCCB_IDX_PC_PULLDN: rd = {6'h00, pc_pulldn_q};
                `PCCB_IDX_PB_OD: rd = pb_od_q;
                `PCCB_IDX_PC_OD: rd = {6'h00, pc_od_q};
                `PCCB_IDX_CMP_SEL: rd = cmp_sel_q;
                `PCCB_IDX_PWR_CTL1: rd = pwr_rd;
                `PCCB_IDX_T1_HIGH: rd = {2'b00, t1_high_q, 4'h0};
                default: rd = 8'h00;
            endcase
        end
    end

    assign PRDATA_O = (acc && !PWRITE_I) ? {24'h000000, rd} : 32'h00000000;

endmodule // pccb_bank
`default_nettype wire

//--- test/pccb_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pccb_bank_sva #(
    parameter ADDR_W = 12,
    parameter IRQ_N = 8
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic [7:0] PRESCALER0_COUNT_I,
    input wire logic IRQ_ON_INSTRUCTION_I,
    input wire logic IRQ_OFF_INSTRUCTION_I,
    input wire logic [IRQ_N-1:0] IRQ_ENABLED_REQ_I,
    input wire logic IRQ_TAKE_O,
    input wire logic GLOBAL_IRQ_ENABLE_O,
    input wire logic [1:0] PORT_C_DIR_O,
    input wire logic [7:0] PORT_A_PULLHIGH_EN_O,
    input wire logic PORT_A5_PULLLOW_EN_O,
    input wire logic [1:0] PORT_C_PULLLOW_EN_O,
    input wire logic [7:0] PORT_B_OPENDRAIN_O,
    input wire logic CMP_PAIR_MODE_O,
    input wire logic [3:0] CMP_REF_LEVEL_O,
    input wire logic [2:0] LVD_THRESHOLD_SEL_O,
    input wire logic [9:0] TIMER1_COUNT_O
);
default clocking cb @(posedge CORE_CLK_I); endclocking
default disable iff (!RSTN_I);
// upper address bits must be clear, else the access is unmapped
wire acc = PSEL_I && PENABLE_I && ((PADDR_I >> 7) == 0);
wire wr = acc && PWRITE_I;
wire rd = acc && !PWRITE_I;
wire [6:0] wa = PADDR_I[6:0];
////////////////////////////////////////////////////////////////////////
AST_DIR: assert property (wr && wa == 7'h1c |=>
    PORT_C_DIR_O == $past(PWDATA_I[1:0])) else $error("direction bad");
AST_PA_PULL: assert property (wr && wa == 7'h24 |=>
    PORT_A_PULLHIGH_EN_O == (~$past(PWDATA_I[7:0]) & 8'hdf) &&
    PORT_A5_PULLLOW_EN_O == !$past(PWDATA_I[5])) else $error("pa pull bad");
AST_PC_PULL: assert property (wr && wa == 7'h2c |=>
    PORT_C_PULLLOW_EN_O == ~$past(PWDATA_I[1:0])) else $error("pc pull bad");
AST_PB_OD: assert property (wr && wa == 7'h30 |=>
    PORT_B_OPENDRAIN_O == $past(PWDATA_I[7:0])) else $error("pb od bad");
// comparator routing is registered once more behind the select register
AST_CMP: assert property (wr && wa == 7'h38 |=> ##1
    CMP_PAIR_MODE_O == ($past(PWDATA_I[3:0], 2) == 4'h0) &&
    CMP_REF_LEVEL_O == $past(PWDATA_I[3:0], 2)) else $error("cmp bad");
AST_LVDS: assert property (wr && wa == 7'h3c |=>
    LVD_THRESHOLD_SEL_O == $past(PWDATA_I[4:2])) else $error("lvds bad");
AST_GIE_ON: assert property (IRQ_ON_INSTRUCTION_I |=>
    GLOBAL_IRQ_ENABLE_O) else $error("gie not set");
AST_GIE_OFF: assert property (IRQ_OFF_INSTRUCTION_I &&
    !IRQ_ON_INSTRUCTION_I |=> !GLOBAL_IRQ_ENABLE_O) else $error("gie kept");
AST_IRQ: assert property (IRQ_TAKE_O ==
    (GLOBAL_IRQ_ENABLE_O && (|IRQ_ENABLED_REQ_I))) else $error("irq gate");
AST_PS0: assert property (rd && wa == 7'h28 |->
    PRDATA_O == {24'h0, PRESCALER0_COUNT_I}) else $error("ps0 read bad");
AST_T1_WR: assert property (wr && wa == 7'h00 |=>
    TIMER1_COUNT_O[7:0] == $past(PWDATA_I[7:0])) else $error("t1 load bad");
AST_T1_RD: assert property (rd && wa == 7'h00 |->
    PRDATA_O[7:0] == TIMER1_COUNT_O[7:0]) else $error("t1 read bad");
endmodule // pccb_bank_sva
bind pccb_bank pccb_bank_sva #(.ADDR_W(ADDR_W), .IRQ_N(IRQ_N)) u_sva (.*);
`default_nettype wire

//--- test/pccb_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pccb_consts.vh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
end
module pccb_bank_bench;
logic CORE_CLK_I = 0, RSTN_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
logic [11:0] PADDR_I = '0;
logic [31:0] PWDATA_I = '0;
logic [7:0] PRESCALER0_COUNT_I = '0, IRQ_ENABLED_REQ_I = '0;
logic LOW_VOLTAGE_FLAG_I = 0, TIMER1_DEC_I = 0;
logic IRQ_ON_INSTRUCTION_I = 0, IRQ_OFF_INSTRUCTION_I = 0;
wire [31:0] PRDATA_O;
wire PREADY_O, PSLVERR_O, IRQ_TAKE_O, GLOBAL_IRQ_ENABLE_O, TIMER0_EN_O;
wire PORT_A5_PULLLOW_EN_O, CMP_PAIR_MODE_O, CMP_POS_VALID_O;
wire [1:0] PORT_C_DIR_O, PORT_C_PULLLOW_EN_O, PORT_C_OPENDRAIN_O;
wire [7:0] PORT_A_PULLHIGH_EN_O, PORT_B_OPENDRAIN_O;
wire CMP_NEG_IS_PAD_O;
wire [3:0] CMP_REF_LEVEL_O, CMP_POS_PAD_O, CMP_NEG_PAD_O;
wire [2:0] LVD_THRESHOLD_SEL_O;
wire [9:0] TIMER1_COUNT_O;
int fails = 0, compares = 0;
logic [31:0] q;
logic err;
logic [3:0] c, v, p, n;
always #20 CORE_CLK_I = ~CORE_CLK_I;
pccb_bank uut (.*);
////////////////////////////////////////////////////////////////////////
// bus requests are held until pready is seen, whatever the slave latency
task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= {5'h0, idx, 2'b00};
    PWDATA_I <= {24'h0, d};
    @(posedge CORE_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CORE_CLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
endtask
task automatic rd_chk(input string nm, input logic [4:0] idx,
                      input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(nm, {24'h0, e}, q)
endtask
task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
initial begin
    repeat (3000) @(posedge CORE_CLK_I);
    fails++;
    print_verdict;
end
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge CORE_CLK_I);
    RSTN_I <= 1'b1;
    rd_chk("dir rst", `PCCB_IDX_PC_DIR, 8'h03);
    rd_chk("pa rst", `PCCB_IDX_PA_PULL, 8'hff);
    rd_chk("pc pull rst", `PCCB_IDX_PC_PULLDN, 8'h03);
    rd_chk("pb od rst", `PCCB_IDX_PB_OD, 8'h00);
    rd_chk("pc od rst", `PCCB_IDX_PC_OD, 8'h00);
    rd_chk("cmp rst", `PCCB_IDX_CMP_SEL, 8'h0c);
    rd_chk("pwr rst", `PCCB_IDX_PWR_CTL1, 8'h1d);
    `CHK("t0en rst", 1'b1, TIMER0_EN_O)
    $display("reset test done");
    xfer(1'b1, `PCCB_IDX_PC_DIR, 8'hfe);
    rd_chk("dir", `PCCB_IDX_PC_DIR, 8'h02);
    `CHK("dir pins", 2'b10, PORT_C_DIR_O)
    xfer(1'b1, `PCCB_IDX_PA_PULL, 8'h5a);
    @(negedge CORE_CLK_I);
    `CHK("pullhigh", 8'h85, PORT_A_PULLHIGH_EN_O)
    `CHK("pa5 low", 1'b1, PORT_A5_PULLLOW_EN_O)
    // pins 6,7 kept off as software must when they carry the crystal
    xfer(1'b1, `PCCB_IDX_PA_PULL, 8'he0);
    @(negedge CORE_CLK_I);
    `CHK("pullhigh", 8'h1f, PORT_A_PULLHIGH_EN_O)
    `CHK("pa5 low", 1'b0, PORT_A5_PULLLOW_EN_O)
    xfer(1'b1, `PCCB_IDX_PC_PULLDN, 8'h01);
    xfer(1'b1, `PCCB_IDX_PB_OD, 8'ha5);
    xfer(1'b1, `PCCB_IDX_PC_OD, 8'hfe);
    rd_chk("pc od", `PCCB_IDX_PC_OD, 8'h02);
    `CHK("pc low", 2'b10, PORT_C_PULLLOW_EN_O)
    `CHK("pb od", 8'ha5, PORT_B_OPENDRAIN_O)
    `CHK("pc od pins", 2'b10, PORT_C_OPENDRAIN_O)
    $display("pad test done");
    // the flag bit must not keep the written 1
    xfer(1'b1, `PCCB_IDX_PWR_CTL1, 8'h42);
    rd_chk("pwr", `PCCB_IDX_PWR_CTL1, 8'h02);
    `CHK("lvds", 3'b000, LVD_THRESHOLD_SEL_O)
    `CHK("t0en", 1'b0, TIMER0_EN_O)
    LOW_VOLTAGE_FLAG_I <= 1'b1;
    IRQ_ENABLED_REQ_I <= 8'h10;
    xfer(1'b1, `PCCB_IDX_PWR_CTL1, 8'hb4);
    rd_chk("pwr", `PCCB_IDX_PWR_CTL1, 8'hf4);
    `CHK("lvds", 3'b101, LVD_THRESHOLD_SEL_O)
    `CHK("take", 1'b1, IRQ_TAKE_O)
    IRQ_OFF_INSTRUCTION_I <= 1'b1;
    @(posedge CORE_CLK_I);
    IRQ_OFF_INSTRUCTION_I <= 1'b0;
    @(negedge CORE_CLK_I);
    `CHK("take off", 1'b0, IRQ_TAKE_O)
    @(posedge CORE_CLK_I);
    IRQ_ON_INSTRUCTION_I <= 1'b1;
    IRQ_OFF_INSTRUCTION_I <= 1'b1;
    @(posedge CORE_CLK_I);
    IRQ_ON_INSTRUCTION_I <= 1'b0;
    IRQ_OFF_INSTRUCTION_I <= 1'b0;
    rd_chk("gie", `PCCB_IDX_PWR_CTL1, 8'hf4);
    $display("power test done");
    for (int m = 0; m < 32; m++) begin
        c = m[3:0];
        v = m[4] ? m[3:0] : 4'h0;
        p = {c[3], {1'b0, c[1:0]} + (c[3] ? 3'd2 : 3'd0)};
        n = {c[2], {1'b0, c[1:0] ^ 2'b01} + (c[2] ? 3'd2 : 3'd0)};
        xfer(1'b1, `PCCB_IDX_CMP_SEL, {c, v});
        @(posedge CORE_CLK_I);
        @(negedge CORE_CLK_I);
        `CHK("pair", v == 4'h0, CMP_PAIR_MODE_O)
        `CHK("neg is pad", v == 4'h0, CMP_NEG_IS_PAD_O)
        `CHK("ref", v, CMP_REF_LEVEL_O)
        if (v == 4'h0) begin
            `CHK("pos pair", p, CMP_POS_PAD_O)
            `CHK("neg pair", n, CMP_NEG_PAD_O)
        end else begin
            `CHK("valid", c != 4'h5, CMP_POS_VALID_O)
            if (c != 4'h5) `CHK("pos", c, CMP_POS_PAD_O)
        end
    end
    $display("comparator test done");
    xfer(1'b1, `PCCB_IDX_T1_HIGH, 8'h30);
    xfer(1'b1, `PCCB_IDX_T1_COUNT, 8'h5a);
    TIMER1_DEC_I <= 1'b1;
    @(negedge CORE_CLK_I);
    `CHK("t1 load", 10'h35a, TIMER1_COUNT_O)
    repeat (3) @(posedge CORE_CLK_I);
    TIMER1_DEC_I <= 1'b0;
    rd_chk("t1 live", `PCCB_IDX_T1_COUNT, 8'h57);
    PRESCALER0_COUNT_I <= 8'h9c;
    xfer(1'b1, `PCCB_IDX_PS0_COUNT, 8'h11);
    rd_chk("ps0", `PCCB_IDX_PS0_COUNT, 8'h9c);
    $display("counter test done");
    xfer(1'b0, 5'h08, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    $display("unmapped test done");
    print_verdict;
end
endmodule // pccb_bank_bench
`default_nettype wire
